// ### logic/uart_irq_regs.vh
// Constants for the UART interrupt, FIFO status and DMA-ready block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register a word.
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH

// Register byte offsets
`define OFS_RX_DATA      8'h00
`define OFS_TX_DATA      8'h04
`define OFS_INT_ENABLE   8'h08
`define OFS_INT_STATUS   8'h0C
`define OFS_FIFO_CTRL    8'h10
`define OFS_LINE_STATUS  8'h14
`define OFS_FIFO_LEVEL   8'h18

// interrupt_enable_reg fields
`define IE_RX_DATA       0
`define IE_TX_EMPTY      1
`define IE_LINE_STAT     2
`define IE_MODEM         3
`define IE_RESET         8'h00

// fifo_control_reg fields
`define FC_ENABLE        0
`define FC_RX_CLEAR      1
`define FC_TX_CLEAR      2
`define FC_DMA_MODE      3
`define FC_TX_TRIG_LO    4
`define FC_RX_TRIG_LO    6
`define FC_RESET         8'h00

// line_status_reg fields
`define LS_DATA_READY    0
`define LS_OVERRUN       1
`define LS_PARITY        2
`define LS_FRAMING       3
`define LS_BREAK         4
`define LS_TX_EMPTY      5
`define LS_TX_IDLE       6
`define LS_FIFO_ERROR    7

// interrupt_status_reg codes
`define IS_NONE          8'h01
`define IS_LINE          8'h06
`define IS_RX_TRIG       8'h04
`define IS_TX_EMPTY      8'h02
`define IS_MODEM         8'h00

// Trigger levels
`define RX_TRIG_0        6'd8
`define RX_TRIG_1        6'd16
`define RX_TRIG_2        6'd24
`define RX_TRIG_3        6'd28
`define TX_TRIG_0        6'd16
`define TX_TRIG_1        6'd8
`define TX_TRIG_2        6'd24
`define TX_TRIG_3        6'd30

`endif

// ### logic/byte_fifo.v
// Small synchronous FIFO of bytes plus error tag, used for both directions.
// Assumes one clock, synchronous active-low reset and a separate clear.
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             clear,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output wire [WIDTH-1:0] head,
  output reg  [AW:0]      count_q
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  wire            do_push;
  wire            do_pop;

  assign do_pop  = pop && (count_q != {(AW+1){1'b0}});
  assign do_push = push && (count_q != DEPTH[AW:0]);
  assign head    = mem_q[rd_q];

  // Pointer and fill tracking
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      wr_q    <= {AW{1'b0}};
      rd_q    <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      if (do_push && !do_pop) count_q <= count_q + 1'b1;
      else if (do_pop && !do_push) count_q <= count_q - 1'b1;
    end
  end

  // Storage write
  always @(posedge aclk) begin
    if (do_push) mem_q[wr_q] <= push_data;
  end
endmodule // byte_fifo

// ### logic/uart_irq_status.v
// UART interrupt enables, FIFO status, interrupt status and DMA ready pins.
// Assumes an AXI4-Lite master and a serial core on the far side that
// hands in received bytes with error flags and takes bytes to send.
`timescale 1ns/1ps
`include "uart_irq_regs.vh"

// How it works
// - Line-status interrupt, when enabled, fires on each received character
// - Transmit interrupt, when enabled, follows transmit-holding empty outside DMA mode 1
// - Receive interrupt rises at trigger fill, falls below it
// - All interrupt enables read zero after reset
// - Receive-data-available shown to host at trigger, removed below it
// - Status code for receive trigger set at level, cleared below
// - Data ready set on character arrival, cleared when FIFO empty
// - Data ready high while bytes held; bits 1-4 report errors
// - Line status bit 5 shows transmit FIFO empty
// - Line status bit 6 shows FIFO and shifter both empty
// - Line status bit 7 flags any error held in receive FIFO
// - DMA mode 0: tx_ready_n low while transmit FIFO is empty
// - DMA mode 0: rx_ready_n low while a character is held
// - DMA mode 1: transmit interrupt while fill below transmit trigger
// - DMA mode 1: receive interrupt at trigger, keep filling to full
// - DMA mode 1: rx_ready_n low while fill at or above trigger
// - Receive trigger codes select 8, 16, 24 or 28 bytes
// - Transmit trigger codes select 16, 8, 24 or 30; default 16
// - Other FIFO control bits take effect only with enable bit written one
// - Enable bit 3 gates modem status interrupt, default off
module uart_irq_status #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char,
  input  wire [3:0]  rx_char_err,
  input  wire        tx_take,
  output reg  [7:0]  tx_char,
  output reg         tx_char_valid,
  input  wire        tx_shift_busy,
  input  wire        modem_event,
  output reg         irq,
  output reg         tx_ready_n,
  output reg         rx_ready_n
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg  [7:0]  ie_q;
  reg  [7:0]  fc_q;
  reg  [1:0]  wst_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         line_evt_q;
  reg         modem_evt_q;
  reg         rx_clr_q;
  reg         tx_clr_q;
  wire [AW:0] rx_cnt;
  wire [AW:0] tx_cnt;
  wire [11:0] rx_head;
  wire [11:0] tx_head;
  wire        fifo_on;
  wire        dma1;
  wire [AW:0] rx_trig;
  wire [AW:0] tx_trig;
  wire        rx_pop;
  wire        tx_push;
  wire        tx_pop;
  wire        wr_fire;
  wire        rd_fire;
  wire        rx_at_trig;
  wire        tx_below;
  wire        tx_empty;
  wire        rx_err_any;
  wire [7:0]  line_stat;
  reg  [7:0]  int_code;
  reg  [AW:0] err_cnt_q;
  wire        rx_full;
  wire        tx_full;
  wire [7:0]  s_axi_wdata_b;

  // Receive trigger decode
  function [AW:0] rx_level;
    input [1:0] code;
    begin
      case (code)
        2'b00:   rx_level = `RX_TRIG_0;
        2'b01:   rx_level = `RX_TRIG_1;
        2'b10:   rx_level = `RX_TRIG_2;
        default: rx_level = `RX_TRIG_3;
      endcase
    end
  endfunction

  // Transmit trigger decode
  function [AW:0] tx_level;
    input [1:0] code;
    begin
      case (code)
        2'b00:   tx_level = `TX_TRIG_0;
        2'b01:   tx_level = `TX_TRIG_1;
        2'b10:   tx_level = `TX_TRIG_2;
        default: tx_level = `TX_TRIG_3;
      endcase
    end
  endfunction

  assign fifo_on  = fc_q[`FC_ENABLE];
  assign dma1     = fifo_on && fc_q[`FC_DMA_MODE];
  assign rx_trig  = fifo_on ? rx_level(fc_q[`FC_RX_TRIG_LO+1:`FC_RX_TRIG_LO])
                            : {{AW{1'b0}}, 1'b1};
  assign tx_trig  = tx_level(fc_q[`FC_TX_TRIG_LO+1:`FC_TX_TRIG_LO]);
  assign rx_full  = fifo_on ? (rx_cnt == DEPTH[AW:0])
                            : (rx_cnt != {(AW+1){1'b0}});
  assign tx_full  = fifo_on ? (tx_cnt == DEPTH[AW:0])
                            : (tx_cnt != {(AW+1){1'b0}});
  assign wr_fire  = aw_got_q && w_got_q && (wst_q == ST_IDLE);
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rx_pop   = rd_fire && (s_axi_araddr == `OFS_RX_DATA);
  assign tx_push  = wr_fire && (awaddr_q == `OFS_TX_DATA) && wstrb_q[0]
                    && !tx_full;
  assign tx_pop   = tx_take && tx_char_valid;
  assign tx_empty = (tx_cnt == {(AW+1){1'b0}});
  assign rx_at_trig = fifo_on && (rx_cnt >= rx_trig);
  assign tx_below   = dma1 ? (tx_cnt < tx_trig) : tx_empty;
  assign rx_err_any = (err_cnt_q != {(AW+1){1'b0}});

  // Line status assembled from live state
  assign line_stat = {rx_err_any,
                      tx_empty && !tx_shift_busy,
                      tx_empty,
                      rx_head[11:8] & {4{rx_cnt != 0}},
                      rx_cnt != {(AW+1){1'b0}}};

  // Receive FIFO; a single slot when FIFOs are off
  byte_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(AW)) rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (rx_clr_q),
    .push      (rx_char_valid && !rx_full),
    .push_data ({rx_char_err, rx_char}),
    .pop       (rx_pop),
    .head      (rx_head),
    .count_q   (rx_cnt)
  );

  // Transmit FIFO
  byte_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(AW)) tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (tx_clr_q),
    .push      (tx_push),
    .push_data ({4'h0, s_axi_wdata_b}),
    .pop       (tx_pop),
    .head      (tx_head),
    .count_q   (tx_cnt)
  );

  // Low byte of the captured write data feeds the transmit FIFO
  assign s_axi_wdata_b = wdata_q[7:0];

  // Count of erroneous characters held in the receive FIFO
  always @(posedge aclk) begin
    if (!aresetn || rx_clr_q) begin
      err_cnt_q <= {(AW+1){1'b0}};
    end else begin
      case ({rx_char_valid && !rx_full && (rx_char_err != 4'h0),
             rx_pop && (rx_cnt != 0) && (rx_head[11:8] != 4'h0)})
        2'b10:   err_cnt_q <= err_cnt_q + 1'b1;
        2'b01:   err_cnt_q <= err_cnt_q - 1'b1;
        default: err_cnt_q <= err_cnt_q;
      endcase
    end
  end

  // Pending sources by priority
  always @* begin
    int_code = `IS_NONE;
    if (line_evt_q && ie_q[`IE_LINE_STAT])
      int_code = `IS_LINE;
    else if (rx_at_trig && ie_q[`IE_RX_DATA])
      int_code = `IS_RX_TRIG;
    else if (!fifo_on && rx_cnt != 0 && ie_q[`IE_RX_DATA])
      int_code = `IS_RX_TRIG;
    else if (tx_below && ie_q[`IE_TX_EMPTY])
      int_code = `IS_TX_EMPTY;
    else if (modem_evt_q && ie_q[`IE_MODEM])
      int_code = `IS_MODEM;
  end

  // Sticky events; a new arrival wins over the clearing read
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_evt_q  <= 1'b0;
      modem_evt_q <= 1'b0;
    end else begin
      if (rx_char_valid) line_evt_q <= 1'b1;
      else if (rd_fire && s_axi_araddr == `OFS_LINE_STATUS)
        line_evt_q <= 1'b0;
      if (modem_event) modem_evt_q <= 1'b1;
      else if (rd_fire && s_axi_araddr == `OFS_INT_STATUS &&
               int_code == `IS_MODEM)
        modem_evt_q <= 1'b0;
    end
  end

  // Pins and transmit handoff, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq           <= 1'b0;
      tx_ready_n    <= 1'b0;
      rx_ready_n    <= 1'b1;
      tx_char       <= 8'h00;
      tx_char_valid <= 1'b0;
    end else begin
      irq           <= (int_code != `IS_NONE);
      tx_ready_n    <= dma1 ? tx_full : !tx_empty;
      if (dma1)
        rx_ready_n <= !(rx_cnt > rx_trig || rx_cnt == rx_trig);
      else
        rx_ready_n <= (rx_cnt == {(AW+1){1'b0}});
      tx_char       <= tx_head[7:0];
      tx_char_valid <= !tx_empty && !tx_pop && !tx_clr_q;
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      wst_q         <= ST_IDLE;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      ie_q          <= `IE_RESET;
      fc_q          <= `FC_RESET;
      rx_clr_q      <= 1'b0;
      tx_clr_q      <= 1'b0;
    end else begin
      rx_clr_q      <= 1'b0;
      tx_clr_q      <= 1'b0;
      s_axi_awready <= !aw_got_q && !s_axi_awready && wst_q == ST_IDLE;
      s_axi_wready  <= !w_got_q && !s_axi_wready && wst_q == ST_IDLE;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q      <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (wst_q)
        ST_IDLE: begin
          if (wr_fire) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            wst_q        <= ST_RESP;
            case (awaddr_q)
              `OFS_TX_DATA: ;
              `OFS_INT_ENABLE: begin
                if (wstrb_q[0]) ie_q <= {4'h0, wdata_q[3:0]};
              end
              `OFS_FIFO_CTRL: begin
                if (wstrb_q[0]) begin
                  if (wdata_q[`FC_ENABLE]) begin
                    fc_q     <= {wdata_q[7:4], wdata_q[3], 3'b001};
                    rx_clr_q <= wdata_q[`FC_RX_CLEAR] || !fc_q[0];
                    tx_clr_q <= wdata_q[`FC_TX_CLEAR] || !fc_q[0];
                  end else begin
                    fc_q     <= {fc_q[7:1], 1'b0};
                    rx_clr_q <= fc_q[0];
                    tx_clr_q <= fc_q[0];
                  end
                end
              end
              default: s_axi_bresp <= 2'b10;
            endcase
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_q        <= ST_IDLE;
          end
        end
        default: wst_q <= ST_IDLE;
      endcase
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        case (s_axi_araddr)
          `OFS_RX_DATA:     s_axi_rdata <= {24'h0, rx_head[7:0]};
          `OFS_TX_DATA:     s_axi_rdata <= 32'h00000000;
          `OFS_INT_ENABLE:  s_axi_rdata <= {24'h0, ie_q};
          `OFS_INT_STATUS:  s_axi_rdata <= {24'h0, fifo_on, fifo_on,
                                           2'b00, int_code[3:0]};
          `OFS_FIFO_CTRL:   s_axi_rdata <= {24'h0, fc_q};
          `OFS_LINE_STATUS: s_axi_rdata <= {24'h0, line_stat};
          `OFS_FIFO_LEVEL:  s_axi_rdata <= {18'h0, tx_cnt, 2'b00,
                                           rx_cnt};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // uart_irq_status

// ### bench/uart_irq_status_sva.sv
// Port checker for the UART interrupt, status and DMA-ready block.
// Assumes it is bound to uart_irq_status and sees only its ports.
`timescale 1ns/1ps
module uart_irq_status_chk #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        rx_char_valid,
  input wire        tx_char_valid,
  input wire        irq,
  input wire        tx_ready_n,
  input wire        rx_ready_n
);
  // Anything that may move the receive ready pin
  wire act = rx_char_valid | s_axi_bvalid | s_axi_rvalid |
             (s_axi_arvalid & s_axi_arready);
  reg  act_q;
  always @(posedge aclk) begin
    act_q <= aresetn ? act : 1'b1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst_quiet;
    $rose(aresetn) |-> !irq [*4];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("irq raised right after reset");
  property p_rx_idle;
    !act && !act_q && rx_ready_n |=> rx_ready_n;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("rx ready fell with no character");
  property p_rx_keep;
    !act && !act_q && !rx_ready_n |=> !rx_ready_n;
  endproperty
  a_rx_keep: assert property (p_rx_keep)
    else $error("rx ready rose with no read");
  property p_tx_empty;
    (!tx_char_valid && !s_axi_bvalid) [*3] |-> !tx_ready_n;
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("tx ready high with empty transmit side");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped before taken");
  property p_wr_answer;
    s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
endmodule // uart_irq_status_chk

bind uart_irq_status uart_irq_status_chk #(.DEPTH(DEPTH), .AW(AW))
  i_uart_irq_status_chk (.aclk, .aresetn, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_char_valid,
  .tx_char_valid, .irq, .tx_ready_n, .rx_ready_n);

// ### bench/serial_far_end.sv
// Behavioural serial core on the far side of the block.
// Assumes the bench calls send and modem from a clocked sequence.
`timescale 1ns/1ps
module serial_far_end #(
  parameter SHIFT = 40
) (
  input  wire       aclk,
  input  wire       hold_tx,
  input  wire [7:0] tx_char,
  input  wire       tx_char_valid,
  output reg        tx_take,
  output reg        tx_shift_busy,
  output reg        rx_char_valid,
  output reg  [7:0] rx_char,
  output reg  [3:0] rx_char_err,
  output reg        modem_event,
  output reg  [7:0] last_char
);
  integer cnt = 0;
  initial begin
    {tx_take, tx_shift_busy, rx_char_valid, modem_event} = 4'h0;
    {rx_char, rx_char_err, last_char} = 20'h0;
  end
  // Take one character, then stay busy while it shifts out
  always @(posedge aclk) begin
    tx_take <= 1'b0;
    if (tx_char_valid && !hold_tx && cnt == 0 && !tx_take) begin
      tx_take <= 1'b1;
      last_char <= tx_char;
      tx_shift_busy <= 1'b1;
      cnt <= SHIFT;
    end else if (cnt != 0) cnt <= cnt - 1;
    else tx_shift_busy <= 1'b0;
  end
  // One received character; lines scrambled once it is gone
  task send(input [7:0] b, input [3:0] e);
    begin
      @(posedge aclk);
      rx_char_valid <= 1'b1;
      rx_char <= b;
      rx_char_err <= e;
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rx_char <= ~b;
      rx_char_err <= ~e;
    end
  endtask
  task modem;
    begin
      @(posedge aclk);
      modem_event <= 1'b1;
      @(posedge aclk);
      modem_event <= 1'b0;
    end
  endtask
endmodule // serial_far_end

// ### bench/test_uart_irq_status.sv
// Self-checking bench for the UART interrupt, status and DMA-ready block.
// Assumes an AXI4-Lite master here and the serial model on the far side.
`timescale 1ns/1ps
module test_uart_irq_status;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0, hold_tx = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, rx_char_valid, tx_take, tx_char_valid;
  wire        tx_shift_busy, modem_event, irq, tx_ready_n, rx_ready_n;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  rx_char, tx_char, last_char;
  wire [3:0]  rx_char_err;
  reg  [31:0] d;
  reg  [1:0]  r;
  integer     fail_count = 0, tests_run = 0, cyc = 0, c, i;
  localparam [23:0] RXT = {6'd28, 6'd24, 6'd16, 6'd8};
  localparam [23:0] TXT = {6'd30, 6'd24, 6'd8, 6'd16};

  uart_irq_status i_uart_irq_status (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_char_valid, .rx_char, .rx_char_err, .tx_take, .tx_char,
    .tx_char_valid, .tx_shift_busy, .modem_event, .irq, .tx_ready_n,
    .rx_ready_n);
  serial_far_end i_serial_far_end (.aclk, .hold_tx, .tx_char,
    .tx_char_valid, .tx_take, .tx_shift_busy, .rx_char_valid, .rx_char,
    .rx_char_err, .modem_event, .last_char);

  // Clock and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end

  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: address and data offered together, each released when taken
  task wr(input [7:0] a, input [31:0] v);
    reg done;
    begin
      done = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          done = 1;
        end
      end
    end
  endtask
  task rd(input [7:0] a);
    reg done;
    begin
      done = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          done = 1;
        end
      end
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask

  // Reset values, unmapped address, single-character mode
  task t_reset;
    begin
      wr(8'h1C, 32'hFF);
      chk(r, 2'h2);
      rdchk(8'h08, 32'h0);
      rdchk(8'h14, 32'h60);
      rdchk(8'h0C, 32'h01);
      chk(irq, 1'b0);
      chk({tx_ready_n, rx_ready_n}, 2'b01);
      rd(8'h1C);
      chk(r, 2'h2);
      i_serial_far_end.send(8'hA5, 4'h0);
      idle(3);
      chk(rx_ready_n, 1'b0);
      rdchk(8'h00, 32'hA5);
      idle(3);
      chk(rx_ready_n, 1'b1);
    end
  endtask
  // Enable bits, upper half reads zero, transmit-empty source
  task t_ie;
    begin
      rdchk(8'h14, 32'h60);
      wr(8'h08, 32'hFF);
      chk(r, 2'h0);
      rdchk(8'h08, 32'h0F);
      idle(2);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'h02);
      wr(8'h08, 32'h01);
      i_serial_far_end.send(8'h22, 4'h0);
      idle(3);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'h04);
      rdchk(8'h00, 32'h22);
      wr(8'h08, 32'h00);
      idle(2);
      chk(irq, 1'b0);
    end
  endtask
  // Receive trigger in FIFO mode 0
  task t_rx;
    begin
      wr(8'h10, 32'h01);
      wr(8'h08, 32'h01);
      for (i = 0; i < 7; i = i + 1) i_serial_far_end.send(8'h30 + i, 4'h0);
      idle(3);
      chk({irq, rx_ready_n}, 2'b00);
      rdchk(8'h14, 32'h61);
      i_serial_far_end.send(8'h37, 4'h0);
      idle(3);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'hC4);
      rdchk(8'h00, 32'h30);
      idle(2);
      chk(irq, 1'b0);
      rdchk(8'h0C, 32'hC1);
      for (i = 1; i < 8; i = i + 1) rdchk(8'h00, 32'h30 + i);
      rdchk(8'h14, 32'h60);
      chk(rx_ready_n, 1'b1);
      wr(8'h08, 32'h00);
    end
  endtask
  // Every receive trigger code in DMA mode 1
  task t_codes;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        wr(8'h10, 32'h09 | (c << 6));
        for (i = 1; i < RXT[c*6+:6]; i = i + 1)
          i_serial_far_end.send(i, 4'h0);
        idle(3);
        chk(rx_ready_n, 1'b1);
        i_serial_far_end.send(8'h77, 4'h0);
        idle(3);
        chk(rx_ready_n, 1'b0);
        rdchk(8'h18, RXT[c*6+:6]);
        if (c == 3) begin
          for (i = 0; i < 4; i = i + 1) i_serial_far_end.send(i, 4'h0);
          rdchk(8'h18, 32'd32);
        end
        wr(8'h10, 32'h0B | (c << 6));
        idle(3);
        chk(rx_ready_n, 1'b1);
      end
    end
  endtask
  // Transmit ready in both modes and every transmit trigger code
  task t_tx;
    begin
      wr(8'h10, 32'h01);
      hold_tx <= 1'b1;
      wr(8'h04, 32'h55);
      idle(2);
      chk(tx_ready_n, 1'b1);
      hold_tx <= 1'b0;
      idle(6);
      chk({tx_ready_n, last_char}, 9'h055);
      hold_tx <= 1'b1;
      wr(8'h08, 32'h02);
      for (c = 0; c < 4; c = c + 1) begin
        wr(8'h10, 32'h0D | (c << 4));
        for (i = 1; i < TXT[c*6+:6]; i = i + 1) wr(8'h04, i);
        idle(2);
        chk(irq, 1'b1);
        wr(8'h04, 32'hEE);
        idle(2);
        chk({irq, tx_ready_n}, 2'b00);
        rdchk(8'h18, TXT[c*6+:6] << 8);
      end
      wr(8'h04, 32'hEE);
      wr(8'h04, 32'hEE);
      idle(2);
      chk(tx_ready_n, 1'b1);
      rdchk(8'h14, 32'h00);
      hold_tx <= 1'b0;
      d = 32'h0;
      while (!d[5]) rd(8'h14);
      idle(2);
      rdchk(8'h14, 32'h20);
      chk(last_char, 8'hEE);
      idle(50);
      rdchk(8'h14, 32'h60);
      wr(8'h08, 32'h00);
    end
  endtask
  // Line errors, masking, polled mode and modem source
  task t_err;
    begin
      wr(8'h10, 32'h01);
      wr(8'h08, 32'h04);
      i_serial_far_end.send(8'h5A, 4'h2);
      idle(3);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'hC6);
      rdchk(8'h14, 32'hE5);
      idle(2);
      chk(irq, 1'b0);
      rdchk(8'h00, 32'h5A);
      rdchk(8'h14, 32'h60);
      wr(8'h08, 32'h00);
      i_serial_far_end.send(8'h11, 4'h0);
      idle(3);
      chk(irq, 1'b0);
      rdchk(8'h14, 32'h61);
      rdchk(8'h00, 32'h11);
      wr(8'h08, 32'h08);
      i_serial_far_end.modem;
      idle(3);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'hC0);
      idle(2);
      chk(irq, 1'b0);
    end
  endtask

  // Main sequence
  initial begin
    idle(10);
    aresetn <= 1'b1;
    t_reset;
    t_ie;
    t_rx;
    t_codes;
    t_tx;
    t_err;
    close_out;
  end
endmodule // test_uart_irq_status
